// [bench/panel_checker.sv]
`timescale 1ns/1ns
`default_nettype none
module panel_checker
   import panel_pkg::*;
(
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Register bus
   input wire logic arvalid,
   input wire logic arready,
   input wire logic rvalid,
   input wire logic rready,
   input wire logic [31:0] rdata,
   input wire logic bvalid,
   input wire logic bready,
   input wire logic [1:0] bresp,
   // Panel and processor bus
   input wire panel_pkg::pbus_out_t pbus_o,
   input wire logic pbus_ack,
   input wire logic [15:0] pbus_data_i,
   input wire logic [15:0] data_lights,
   input wire logic run_light,
   input wire logic master_clear_line
);
   logic [8:0] mclr_cnt_ff;
   logic [8:0] nxt_mclr_cnt;
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // Length of the pulse seen so far
   always_comb
      nxt_mclr_cnt = master_clear_line ? mclr_cnt_ff + 9'h001 : 9'h000;
   always_ff @(posedge aclk) begin
      mclr_cnt_ff <= aresetn ? nxt_mclr_cnt : 9'h000;
   end
   sequence s_taken;
      pbus_o.req && pbus_ack;
   endsequence
   sequence s_next_free;
      !pbus_o.req ##1 !pbus_o.req;
   endsequence
   a_bus_hold: assert property (
      pbus_o.req && $past(pbus_o.req) |->
      $stable({pbus_o.addr, pbus_o.write, pbus_o.data}))
      else $error("bus lines moved during request");
   a_store_drive: assert property (
      pbus_o.data_oe_n == !(pbus_o.req && pbus_o.write))
      else $error("data enable does not match store");
   a_req_drop: assert property (s_taken |=> s_next_free)
      else $error("request held after acknowledge");
   a_req_rise: assert property ($rose(pbus_o.req) |-> !pbus_ack)
      else $error("request raised while ack still high");
   a_clear_len: assert property (
      $fell(master_clear_line) |-> mclr_cnt_ff == 9'h0FA)
      else $error("master clear pulse length wrong");
   a_run_watch: assert property (
      run_light && $past(run_light) |-> data_lights == $past(pbus_data_i))
      else $error("lights do not follow data bus");
   a_read_answer: assert property (arvalid && arready |=> rvalid)
      else $error("read answer late");
   a_read_hold: assert property (
      rvalid && !rready |=> rvalid && $stable(rdata))
      else $error("read data dropped early");
   a_wr_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
      else $error("write response dropped early");
endmodule
bind operator_panel panel_checker u_chk (.aclk(aclk), .aresetn(aresetn),
   .arvalid(arvalid), .arready(arready), .rvalid(rvalid), .rready(rready),
   .rdata(rdata), .bvalid(bvalid), .bready(bready), .bresp(bresp),
   .pbus_o(pbus_o), .pbus_ack(pbus_ack), .pbus_data_i(pbus_data_i),
   .data_lights(data_lights), .run_light(run_light),
   .master_clear_line(master_clear_line));
`default_nettype wire

// [bench/pbus_mem.sv]
`timescale 1ns/1ns
`default_nettype none
module pbus_mem
   import panel_pkg::*;
(
   // Clock and pacing
   input wire logic aclk,
   input wire logic [3:0] lat,
   // Processor bus
   input wire panel_pkg::pbus_out_t bus,
   output logic ack = 1'b0,
   output logic [15:0] dout = 16'h0000,
   // Counters and last written word for the bench
   output int nwr = 0,
   output int nrd = 0,
   output logic [15:0] lwd = 16'h0000
);
   logic [15:0] mem [logic [15:0]];
   int w = 0;
   always @(posedge aclk) begin
      // Released bus never holds its last word
      if (!ack) dout <= ~dout;
      // ack once written or data driven
      if (bus.req && !ack) begin
         if (w < int'(lat)) begin
            w <= w + 1;
         end else begin
            w <= 0;
            ack <= 1'b1;
            if (bus.write) begin
               mem[bus.addr] = bus.data;
               lwd <= bus.data;
               nwr <= nwr + 1;
            end else begin
               dout <= mem.exists(bus.addr) ? mem[bus.addr] : ~bus.addr;
               nrd <= nrd + 1;
            end
         end
      end else if (!bus.req && ack) begin
         ack <= 1'b0;
      end
   end
endmodule
`default_nettype wire

// [bench/tb_top.sv]
`timescale 1ns/1ns
`default_nettype none
module tb_top;
   import panel_pkg::*;
   typedef struct {
      panel_mode_t m;
      logic [2:0] s;
      logic [15:0] sw, lt, par, lw;
      int nw;
   } row_t;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [7:0] awaddr = 8'h00;
   logic [7:0] araddr = 8'h00;
   logic [31:0] wdata = 32'h0;
   logic [3:0] wstrb = 4'hF;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
   logic arvalid = 1'b0, rready = 1'b0, execute_btn = 1'b0;
   logic awready, wready, bvalid, arready, rvalid, run_light;
   logic master_clear_line, pbus_ack;
   logic [1:0] bresp, rresp, r;
   logic [31:0] rdata, d;
   logic [15:0] data_lights, pbus_data_i, lwd;
   logic [3:0] lat = 4'h0;
   pbus_out_t pbus_o;
   panel_in_t panel_i = '0;
   int n_fail = 0;
   int compares = 0;
   int nwr, nrd, w0, k;
   row_t rows [10];

   always #2 aclk = ~aclk;

   operator_panel #(.DEBOUNCE_CYC(4)) uut (.aclk(aclk), .aresetn(aresetn),
      .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
      .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
      .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
      .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
      .rready(rready), .panel_i(panel_i), .execute_btn(execute_btn),
      .data_lights(data_lights), .run_light(run_light), .pbus_o(pbus_o),
      .pbus_ack(pbus_ack), .pbus_data_i(pbus_data_i),
      .master_clear_line(master_clear_line));
   pbus_mem u_mem (.aclk(aclk), .lat(lat), .bus(pbus_o), .ack(pbus_ack),
      .dout(pbus_data_i), .nwr(nwr), .nrd(nrd), .lwd(lwd));

   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         n_fail++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] v,
                     output logic [1:0] rs);
      logic ah, wh, bh, vh;
      int t;
      t = 0;
      @(posedge aclk);
      awaddr <= a;
      wdata <= v;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      do begin
         @(negedge aclk);
         ah = awvalid && awready;
         wh = wvalid && wready;
         vh = bvalid;
         bh = vh && bready;
         rs = bresp;
         @(posedge aclk);
         if (ah) awvalid <= 1'b0;
         if (wh) wvalid <= 1'b0;
         if (vh && !bh) bready <= 1'b1;
         t++;
      end while (!bh && t < 100);
      bready <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, output logic [31:0] v,
                     output logic [1:0] rs);
      logic ah, rh, vh;
      int t;
      t = 0;
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      do begin
         @(negedge aclk);
         ah = arvalid && arready;
         vh = rvalid;
         rh = vh && rready;
         v = rdata;
         rs = rresp;
         @(posedge aclk);
         if (ah) arvalid <= 1'b0;
         if (vh && !rh) rready <= 1'b1;
         t++;
      end while (!rh && t < 100);
      rready <= 1'b0;
   endtask

   // Poll busy; settle before looking at outputs
   task automatic idle();
      int t;
      t = 0;
      do begin
         rd(8'h04, d, r);
         t++;
      end while (d[0] !== 1'b0 && t < 300);
      @(negedge aclk);
   endtask

   task automatic print_verdict();
      $display("fails %0d compares %0d", n_fail, compares);
      if (n_fail == 0 && compares > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   initial begin
      #200000;
      n_fail++;
      print_verdict();
   end

   initial begin
      rows = '{
         '{MODE_ADDR_SEL, 3'h0, 16'h0100, 16'h0100, 16'h0100, 16'h0000, 0},
         '{MODE_STORE_INC, 3'h0, 16'hA5C3, 16'hFEFE, 16'h0101, 16'hA5C3, 1},
         '{MODE_STORE, 3'h0, 16'h1234, 16'h1234, 16'h0101, 16'h1234, 1},
         '{MODE_FETCH_INC, 3'h0, 16'hFFFF, 16'h1234, 16'h0102, 16'h1234, 0},
         '{MODE_FETCH, 3'h0, 16'h0000, 16'hFEFD, 16'h0102, 16'h1234, 0},
         '{MODE_REG_SEL, 3'h3, 16'hBEEF, 16'hBEEF, 16'h0102, 16'hBEEF, 1},
         '{MODE_HALT, 3'h3, 16'h0000, 16'hBEEF, 16'h0102, 16'h0002, 2},
         '{MODE_SINGLE_INSTRUCTION, 3'h3, 16'h0, 16'hBEEF, 16'h0102,
           16'h0006, 2},
         '{MODE_MASTER_CLEAR, 3'h7, 16'h0, 16'h00E8, 16'h0102, 16'h0006, 0},
         '{panel_mode_t'(4'hA), 3'h0, 16'h0, 16'h00E8, 16'h0102, 16'h0006, 0}};
      repeat (4) @(posedge aclk);
      aresetn <= 1'b1;
      @(negedge aclk);
      cmp(data_lights, 32'h0);
      cmp(pbus_o.data_oe_n, 32'h1);
      rd(8'h04, d, r);
      cmp(d, 32'h0);
      for (int i = 0; i < 10; i++) begin
         lat <= (i > 4) ? 4'h5 : 4'h0;
         panel_i <= '{rows[i].m, rows[i].s, rows[i].sw};
         w0 = nwr;
         wr(8'h00, 32'h1, r);
         idle();
         cmp(data_lights, rows[i].lt);
         cmp(lwd, rows[i].lw);
         cmp(32'(nwr - w0), 32'(rows[i].nw));
         rd(8'h08, d, r);
         cmp(d, rows[i].par);
      end
      panel_i <= '{MODE_RUN, 3'h0, 16'h0000};
      w0 = nwr;
      wr(8'h00, 32'h1, r);
      k = 0;
      while (run_light !== 1'b1 && k < 200) begin
         @(negedge aclk);
         k++;
      end
      cmp(lwd, 16'h0004);
      cmp(32'(nwr - w0), 32'h2);
      rd(8'h04, d, r);
      cmp(d[1], 1'b1);
      panel_i <= '{MODE_FETCH, 3'h0, 16'h0000};
      w0 = nrd;
      execute_btn <= 1'b1;
      repeat (2) @(posedge aclk);
      execute_btn <= 1'b0;
      repeat (20) @(posedge aclk);
      cmp(32'(nrd - w0), 32'h0);
      execute_btn <= 1'b1;
      repeat (30) @(posedge aclk);
      execute_btn <= 1'b0;
      repeat (40) @(posedge aclk);
      @(negedge aclk);
      cmp(32'(nrd - w0), 32'h1);
      cmp(data_lights, 16'hFEFD);
      cmp(run_light, 1'b0);
      wr(8'h08, 32'h0200, r);
      panel_i <= '{MODE_MASTER_CLEAR, 3'h3, 16'h0000};
      wr(8'h00, 32'h1, r);
      wr(8'h08, 32'h0300, r);
      cmp(r, 2'h0);
      idle();
      cmp(data_lights, 16'hBEEF);
      rd(8'h08, d, r);
      cmp(d, 32'h0200);
      rd(8'h0C, d, r);
      cmp(d, 32'hBEEF);
      wr(8'h00, 32'h2, r);
      execute_btn <= 1'b1;
      repeat (30) @(negedge aclk);
      cmp(master_clear_line, 1'b0);
      wr(8'h14, 32'h1, r);
      cmp(r, 2'h2);
      rd(8'h14, d, r);
      cmp(r, 2'h2);
      print_verdict();
   end
endmodule
`default_nettype wire

// [design/exec_debounce.sv]
`timescale 1ns/1ns
`default_nettype none
module exec_debounce #(
   parameter int DEB_CYC = 1250000
) (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Raw button and clean press
   input wire logic btn_raw,
   output logic press
);
   localparam int CW = $clog2(DEB_CYC + 1);

   typedef struct packed {
      logic s1;
      logic s2;
      logic level;
      logic [CW-1:0] cnt;
      logic press;
   } deb_state_t;

   deb_state_t state_ff;
   deb_state_t nxt_state;

   always_comb begin
      nxt_state = state_ff;
      nxt_state.s1 = btn_raw;
      nxt_state.s2 = state_ff.s1;
      nxt_state.press = 1'b0;
      // [RQ17] filter bounce
      if (state_ff.s2 == state_ff.level) begin
         nxt_state.cnt = '0;
      end else if (state_ff.cnt == CW'(DEB_CYC - 1)) begin
         nxt_state.cnt = '0;
         nxt_state.level = state_ff.s2;
         nxt_state.press = state_ff.s2;
      end else begin
         nxt_state.cnt = state_ff.cnt + CW'(1);
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state_ff <= '0;
      end else begin
         state_ff <= nxt_state;
      end
   end

   assign press = state_ff.press;
endmodule
`default_nettype wire

// [design/operator_panel.sv]
// Decided for this implementation: the AXI4-Lite slave port and the address map.
`timescale 1ns/1ns
`default_nettype none
`include "panel_defines.svh"
// Contract
// [RQ1] Sixteen lights show word, sixteen switches enter
// [RQ2] Decode mode, register selectors and execute
// [RQ3] Switch up is one, MSB leftmost
// [RQ4] Store, increment address, fetch new word
// [RQ5] Fetch into data register, then increment
// [RQ6] Store without increment, fetch back, display
// [RQ7] Fetch into data register, address unchanged
// [RQ8] Load address register from switches, display
// [RQ9] Load selected processor register, display it
// [RQ10] Two control words halt processor
// [RQ11] Two control words run; lights monitor bus
// [RQ12] Two control words run one instruction
// [RQ13] Pulse master clear, display selected register
// [RQ14] Initiator holds address, mode, data during request
// [RQ15] Four-phase: capture, drop request, ack falls
// [RQ16] Memory acknowledges after write or data valid
// [RQ17] Debounced execute starts exactly one action
module operator_panel
   import panel_pkg::*;
#(
   parameter int DEBOUNCE_CYC = `DEBOUNCE_MS * 1000 * `CLK_MHZ,
   parameter logic [15:0] CPU_CTRL_ADDR = 16'hFF00,
   parameter logic [15:0] CPU_REG_BASE = 16'hFF10,
   parameter logic [15:0] HALT_WORD0 = 16'h0001,
   parameter logic [15:0] HALT_WORD1 = 16'h0002,
   parameter logic [15:0] RUN_WORD0 = 16'h0003,
   parameter logic [15:0] RUN_WORD1 = 16'h0004,
   parameter logic [15:0] STEP_WORD0 = 16'h0005,
   parameter logic [15:0] STEP_WORD1 = 16'h0006
) (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // AXI4-Lite write
   input wire logic [7:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   // AXI4-Lite read
   input wire logic [7:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   // Front panel
   input wire panel_pkg::panel_in_t panel_i,
   input wire logic execute_btn,
   output logic [15:0] data_lights,
   output logic run_light,
   // Processor bus and control
   output panel_pkg::pbus_out_t pbus_o,
   input wire logic pbus_ack,
   input wire logic [15:0] pbus_data_i,
   output logic master_clear_line
);
   import panel_pkg::*;

   typedef struct packed {
      seq_t seq;
      logic [1:0] idx;
      panel_mode_t mode;
      logic [2:0] rsel;
      logic [15:0] sw;
      logic [15:0] panel_address_register;
      logic [15:0] panel_data_register;
      logic [15:0] lights;
      logic run_view;
      logic mclr;
      logic [`MCLR_CW-1:0] mcnt;
      logic start;
      logic lock;
      logic soft_exec;
      logic aw_got;
      logic w_got;
      logic [7:0] aw_addr;
      logic [31:0] w_data;
      logic [3:0] w_strb;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [1:0] rresp;
      logic [31:0] rdata;
   } top_state_t;

   top_state_t state_ff;
   top_state_t nxt_state;
   bus_op_t cur_op;
   logic press;
   logic bus_done;
   logic [15:0] bus_rdata;
   logic busy;
   logic trigger;

   exec_debounce #(
      .DEB_CYC(DEBOUNCE_CYC)
   ) u_debounce (
      .aclk(aclk),
      .aresetn(aresetn),
      .btn_raw(execute_btn),
      .press(press)
   );

   pbus_initiator u_bus (
      .aclk(aclk),
      .aresetn(aresetn),
      .start(state_ff.start),
      .write(cur_op.write),
      .addr(cur_op.addr),
      .wdata(cur_op.data),
      .done(bus_done),
      .rdata(bus_rdata),
      .pbus_o(pbus_o),
      .pbus_ack(pbus_ack),
      .pbus_data_i(pbus_data_i)
   );

   // Bus cycles making up each panel action, by step number
   function automatic bus_op_t op_for(input panel_mode_t mode,
                                      input logic [1:0] idx,
                                      input logic [15:0] par,
                                      input logic [15:0] sw,
                                      input logic [2:0] rsel);
      bus_op_t op;
      logic [15:0] reg_addr;
      op = '0;
      reg_addr = CPU_REG_BASE + {13'h0000, rsel};
      unique case (mode)
         // [RQ4] [RQ6] store then fetch; MODE_STORE_INC fetches from the incremented address
         MODE_STORE_INC, MODE_STORE: begin
            if (idx == 2'h0) begin
               op = '{1'b1, 1'b1, par, sw, 1'b0};
            end else if (idx == 2'h1) begin
               op = '{1'b1, 1'b0, par, 16'h0000, 1'b1};
            end
         end
         // [RQ5] [RQ7] single fetch
         MODE_FETCH_INC, MODE_FETCH: begin
            if (idx == 2'h0) begin
               op = '{1'b1, 1'b0, par, 16'h0000, 1'b1};
            end
         end
         // [RQ9] load register then read it back
         MODE_REG_SEL: begin
            if (idx == 2'h0) begin
               op = '{1'b1, 1'b1, reg_addr, sw, 1'b0};
            end else if (idx == 2'h1) begin
               op = '{1'b1, 1'b0, reg_addr, 16'h0000, 1'b1};
            end
         end
         // [RQ10] halt words, then selected register
         MODE_HALT: begin
            if (idx == 2'h0) begin
               op = '{1'b1, 1'b1, CPU_CTRL_ADDR, HALT_WORD0, 1'b0};
            end else if (idx == 2'h1) begin
               op = '{1'b1, 1'b1, CPU_CTRL_ADDR, HALT_WORD1, 1'b0};
            end else if (idx == 2'h2) begin
               op = '{1'b1, 1'b0, reg_addr, 16'h0000, 1'b1};
            end
         end
         // [RQ12] step words, then selected register
         MODE_SINGLE_INSTRUCTION: begin
            if (idx == 2'h0) begin
               op = '{1'b1, 1'b1, CPU_CTRL_ADDR, STEP_WORD0, 1'b0};
            end else if (idx == 2'h1) begin
               op = '{1'b1, 1'b1, CPU_CTRL_ADDR, STEP_WORD1, 1'b0};
            end else if (idx == 2'h2) begin
               op = '{1'b1, 1'b0, reg_addr, 16'h0000, 1'b1};
            end
         end
         // [RQ11] run words only
         MODE_RUN: begin
            if (idx == 2'h0) begin
               op = '{1'b1, 1'b1, CPU_CTRL_ADDR, RUN_WORD0, 1'b0};
            end else if (idx == 2'h1) begin
               op = '{1'b1, 1'b1, CPU_CTRL_ADDR, RUN_WORD1, 1'b0};
            end
         end
         // [RQ13] read register after clear pulse
         MODE_MASTER_CLEAR: begin
            if (idx == 2'h0) begin
               op = '{1'b1, 1'b0, reg_addr, 16'h0000, 1'b1};
            end
         end
         MODE_ADDR_SEL: begin
            op = '0;
         end
         default: begin
            op = '0;
         end
      endcase
      return op;
   endfunction

   assign cur_op = op_for(state_ff.mode, state_ff.idx,
                          state_ff.panel_address_register,
                          state_ff.sw, state_ff.rsel);
   assign busy = (state_ff.seq != SEQ_IDLE);
   // [RQ17] presses while busy are dropped
   assign trigger = !busy &&
                    ((press && !state_ff.lock) || state_ff.soft_exec);

   always_comb begin
      nxt_state = state_ff;
      nxt_state.start = 1'b0;
      nxt_state.soft_exec = 1'b0;

      // Register bus, write channel; address and data in either order
      if (awvalid && awready) begin
         nxt_state.aw_got = 1'b1;
         nxt_state.aw_addr = awaddr;
      end
      if (wvalid && wready) begin
         nxt_state.w_got = 1'b1;
         nxt_state.w_data = wdata;
         nxt_state.w_strb = wstrb;
      end
      if (state_ff.aw_got && state_ff.w_got) begin
         nxt_state.aw_got = 1'b0;
         nxt_state.w_got = 1'b0;
         nxt_state.bvalid = 1'b1;
         nxt_state.bresp = `RESP_OKAY;
         unique case (state_ff.aw_addr)
            `REG_CTRL: begin
               if (state_ff.w_strb[0]) begin
                  nxt_state.soft_exec = state_ff.w_data[`CTRL_EXEC_BIT];
                  nxt_state.lock = state_ff.w_data[`CTRL_LOCK_BIT];
               end
            end
            `REG_PAR: begin
               // Address register is the sequencer's while busy
               if (!busy && state_ff.w_strb[0]) begin
                  nxt_state.panel_address_register[7:0] =
                     state_ff.w_data[7:0];
               end
               if (!busy && state_ff.w_strb[1]) begin
                  nxt_state.panel_address_register[15:8] =
                     state_ff.w_data[15:8];
               end
            end
            `REG_STATUS, `REG_PDR, `REG_LIGHTS: begin
               nxt_state.bresp = `RESP_OKAY;
            end
            default: begin
               nxt_state.bresp = `RESP_SLVERR;
            end
         endcase
      end
      if (state_ff.bvalid && bready) begin
         nxt_state.bvalid = 1'b0;
      end

      // Register bus, read channel
      if (arvalid && arready) begin
         nxt_state.rvalid = 1'b1;
         nxt_state.rresp = `RESP_OKAY;
         nxt_state.rdata = '0;
         unique case (araddr)
            `REG_CTRL: begin
               nxt_state.rdata[`CTRL_LOCK_BIT] = state_ff.lock;
            end
            `REG_STATUS: begin
               nxt_state.rdata[`STAT_BUSY_BIT] = busy;
               nxt_state.rdata[`STAT_RUN_BIT] = state_ff.run_view;
            end
            `REG_PAR: begin
               nxt_state.rdata[15:0] = state_ff.panel_address_register;
            end
            `REG_PDR: begin
               nxt_state.rdata[15:0] = state_ff.panel_data_register;
            end
            `REG_LIGHTS: begin
               nxt_state.rdata[15:0] = state_ff.lights;
            end
            default: begin
               nxt_state.rresp = `RESP_SLVERR;
            end
         endcase
      end else if (state_ff.rvalid && rready) begin
         nxt_state.rvalid = 1'b0;
      end

      // [RQ11] lights follow the processor data bus while running
      if (state_ff.run_view) begin
         nxt_state.lights = pbus_data_i;
      end

      unique case (state_ff.seq)
         SEQ_IDLE: begin
            if (trigger) begin
               // [RQ2] [RQ3] selectors and switch word latched at press
               nxt_state.mode = panel_i.mode;
               nxt_state.rsel = panel_i.reg_sel;
               nxt_state.sw = panel_i.data_sw;
               nxt_state.idx = 2'h0;
               nxt_state.run_view = 1'b0;
               if (panel_i.mode == MODE_ADDR_SEL) begin
                  // [RQ8] address register loaded and shown
                  nxt_state.panel_address_register = panel_i.data_sw;
                  nxt_state.lights = panel_i.data_sw;
               end else if (panel_i.mode == MODE_MASTER_CLEAR) begin
                  // [RQ13] master clear pulse
                  nxt_state.mclr = 1'b1;
                  nxt_state.mcnt = `MCLR_CW'(`MCLR_CYC);
                  nxt_state.seq = SEQ_MCLR;
               end else if (panel_i.mode inside {MODE_STORE_INC,
                      MODE_FETCH_INC, MODE_STORE, MODE_FETCH,
                      MODE_REG_SEL, MODE_HALT, MODE_RUN,
                      MODE_SINGLE_INSTRUCTION}) begin
                  nxt_state.seq = SEQ_ISSUE;
               end
            end
         end
         SEQ_MCLR: begin
            if (state_ff.mcnt == `MCLR_CW'(1)) begin
               nxt_state.mclr = 1'b0;
               nxt_state.seq = SEQ_ISSUE;
            end else begin
               nxt_state.mcnt = state_ff.mcnt - `MCLR_CW'(1);
            end
         end
         SEQ_ISSUE: begin
            if (cur_op.valid) begin
               nxt_state.start = 1'b1;
               nxt_state.seq = SEQ_WAIT;
            end else begin
               nxt_state.seq = SEQ_IDLE;
               // [RQ11] monitor bus once running
               nxt_state.run_view = (state_ff.mode == MODE_RUN);
            end
         end
         SEQ_WAIT: begin
            if (bus_done) begin
               // [RQ1] fetched word shown on the lights
               if (cur_op.show) begin
                  nxt_state.panel_data_register = bus_rdata;
                  nxt_state.lights = bus_rdata;
               end
               // [RQ4] [RQ5] post-increment after first cycle
               if (state_ff.idx == 2'h0 &&
                   (state_ff.mode == MODE_STORE_INC ||
                    state_ff.mode == MODE_FETCH_INC)) begin
                  nxt_state.panel_address_register =
                     state_ff.panel_address_register + `ADDR_INC;
               end
               nxt_state.idx = state_ff.idx + 2'h1;
               nxt_state.seq = SEQ_ISSUE;
            end
         end
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state_ff <= '0;
      end else begin
         state_ff <= nxt_state;
      end
   end

   // Write side stalls while a response is still owed
   assign awready = !state_ff.aw_got && !state_ff.bvalid;
   assign wready = !state_ff.w_got && !state_ff.bvalid;
   assign bvalid = state_ff.bvalid;
   assign bresp = state_ff.bresp;
   assign arready = !state_ff.rvalid;
   assign rvalid = state_ff.rvalid;
   assign rdata = state_ff.rdata;
   assign rresp = state_ff.rresp;
   assign data_lights = state_ff.lights;
   assign run_light = state_ff.run_view;
   assign master_clear_line = state_ff.mclr;
endmodule
`default_nettype wire

// [design/panel_defines.svh]
`ifndef PANEL_DEFINES_SVH
`define PANEL_DEFINES_SVH

`define CLK_MHZ 250
`define DEBOUNCE_MS 5
`define MCLR_NS 1000
`define MCLR_CYC ((`MCLR_NS * `CLK_MHZ + 999) / 1000)
`define MCLR_CW 9

`define REG_CTRL 8'h00
`define REG_STATUS 8'h04
`define REG_PAR 8'h08
`define REG_PDR 8'h0C
`define REG_LIGHTS 8'h10

`define CTRL_EXEC_BIT 0
`define CTRL_LOCK_BIT 1
`define STAT_BUSY_BIT 0
`define STAT_RUN_BIT 1

`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`define ADDR_INC 16'h0001

`endif

// [design/panel_pkg.sv]
package panel_pkg;

   typedef enum logic [3:0] {
      MODE_STORE_INC,
      MODE_FETCH_INC,
      MODE_STORE,
      MODE_FETCH,
      MODE_ADDR_SEL,
      MODE_REG_SEL,
      MODE_HALT,
      MODE_RUN,
      MODE_SINGLE_INSTRUCTION,
      MODE_MASTER_CLEAR
   } panel_mode_t;

   typedef enum logic [1:0] {
      SEQ_IDLE,
      SEQ_ISSUE,
      SEQ_WAIT,
      SEQ_MCLR
   } seq_t;

   // Operator switches as read from the panel
   typedef struct packed {
      panel_mode_t mode;
      logic [2:0] reg_sel;
      logic [15:0] data_sw;
   } panel_in_t;

   // Processor bus lines driven by the panel
   typedef struct packed {
      logic req;
      logic write;
      logic [15:0] addr;
      logic [15:0] data;
      logic data_oe_n;
   } pbus_out_t;

   // One bus cycle of an execute sequence
   typedef struct packed {
      logic valid;
      logic write;
      logic [15:0] addr;
      logic [15:0] data;
      logic show;
   } bus_op_t;

endpackage

// [design/pbus_initiator.sv]
`timescale 1ns/1ns
`default_nettype none
module pbus_initiator
   import panel_pkg::*;
(
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Command side
   input wire logic start,
   input wire logic write,
   input wire logic [15:0] addr,
   input wire logic [15:0] wdata,
   output logic done,
   output logic [15:0] rdata,
   // Processor bus
   output pbus_out_t pbus_o,
   input wire logic pbus_ack,
   input wire logic [15:0] pbus_data_i
);
   typedef struct packed {
      logic busy;
      logic req;
      logic write;
      logic [15:0] addr;
      logic [15:0] data;
      logic [15:0] rdata;
      logic done;
   } ini_state_t;

   ini_state_t state_ff;
   ini_state_t nxt_state;

   always_comb begin
      nxt_state = state_ff;
      nxt_state.done = 1'b0;
      if (!state_ff.busy) begin
         if (start) begin
            // [RQ14] lines loaded in the same cycle as the request
            nxt_state.busy = 1'b1;
            nxt_state.req = 1'b1;
            nxt_state.write = write;
            nxt_state.addr = addr;
            nxt_state.data = wdata;
         end
      end else if (state_ff.req) begin
         if (pbus_ack) begin
            // [RQ15] capture and drop request
            nxt_state.req = 1'b0;
            if (!state_ff.write) begin
               nxt_state.rdata = pbus_data_i;
            end
         end
      end else if (!pbus_ack) begin
         // [RQ15] acknowledge gone, cycle over
         nxt_state.busy = 1'b0;
         nxt_state.done = 1'b1;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state_ff <= '0;
      end else begin
         state_ff <= nxt_state;
      end
   end

   // [RQ14] data driven only during a store request
   assign pbus_o.req = state_ff.req;
   assign pbus_o.write = state_ff.write;
   assign pbus_o.addr = state_ff.addr;
   assign pbus_o.data = state_ff.data;
   assign pbus_o.data_oe_n = ~(state_ff.req & state_ff.write);
   assign done = state_ff.done;
   assign rdata = state_ff.rdata;
endmodule
`default_nettype wire
